// file: hdl/scife_top.sv
// AXI4-Lite register bank for two serial channels' interrupt flags and enables
`timescale 1ns/10ps
`default_nettype none
module scife_top
	import scife_pkg::*;
(
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// AXI4-Lite write address
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [3:0]      s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	// AXI4-Lite write response
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	output logic [1:0]           s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	input  wire logic [3:0]      s_axi_araddr,
	// AXI4-Lite read data
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	output logic [31:0]          s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	// Serial engine events
	input  wire scife_chan_evt_t chan0_evt,
	input  wire scife_chan_evt_t chan1_evt,
	// Interrupt requests
	output scife_chan_irq_t      chan0_irq,
	output scife_chan_irq_t      chan1_irq
);
	logic        aw_held_r;
	logic [3:0]  aw_addr_r;
	logic        w_held_r;
	logic [7:0]  w_data_r;
	logic        w_lane_r;
	logic        wr_go;
	logic        wr_hit;
	logic        ch0_flags_we;
	logic        ch0_ena_we;
	logic        ch1_flags_we;
	logic        ch1_ena_we;
	logic [1:0]  ch0_flags;
	logic [1:0]  ch0_ena;
	logic [1:0]  ch1_flags;
	logic [1:0]  ch1_ena;
	logic [3:0]  ch1_spare;
	logic [7:0]  rd_nxt;
	logic        rd_hit;
	logic [3:0]  wr_sel;
	logic        wr_lane;

	// Address and data are latched separately so either may come first
	// A pending response blocks both halves: one write in flight at a time
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;

	// Held flag drops when the write lands, freeing the address channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			aw_held_r <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			aw_held_r <= 1'b1;
		else if (wr_go)
			aw_held_r <= 1'b0;
	end

	// Address stays put while held, since awready is low then
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			aw_addr_r <= 4'h0;
		else if (s_axi_awvalid && s_axi_awready)
			aw_addr_r <= s_axi_awaddr;
	end

	// Held flag drops when the write lands, freeing the data channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			w_held_r <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			w_held_r <= 1'b1;
		else if (wr_go)
			w_held_r <= 1'b0;
	end

	// Only lane 0 reaches the byte-wide registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_data_r <= 8'h00;
			w_lane_r <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_data_r <= s_axi_wdata[7:0];
			w_lane_r <= s_axi_wstrb[0];
		end
	end

	// One select per register; an address outside the map selects none
	assign wr_sel[0] = (aw_addr_r == SCIFE_OFS_CH0_FLAGS);
	assign wr_sel[1] = (aw_addr_r == SCIFE_OFS_CH0_ENA);
	assign wr_sel[2] = (aw_addr_r == SCIFE_OFS_CH1_ENA);
	assign wr_sel[3] = (aw_addr_r == SCIFE_OFS_CH1_FLAGS);
	assign wr_hit    = |wr_sel;

	// Registers are one byte wide, so only lane 0 matters
	assign wr_lane      = wr_go && w_lane_r;
	assign ch0_flags_we = wr_lane && wr_sel[0];
	assign ch0_ena_we   = wr_lane && wr_sel[1];
	assign ch1_ena_we   = wr_lane && wr_sel[2];
	assign ch1_flags_we = wr_lane && wr_sel[3];

	// Response waits for bready, however long that takes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_bvalid <= 1'b0;
		else if (wr_go)
			s_axi_bvalid <= 1'b1;
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Response code is fixed when the write lands and stands with bvalid
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_bresp <= SCIFE_RESP_OKAY;
		else if (wr_go)
			s_axi_bresp <= wr_hit ? SCIFE_RESP_OKAY : SCIFE_RESP_SLVERR;
	end

	// Channel 0 has no spare bits; its upper bits belong to other modules
	scife_chan #(
		.HAS_SPARE (1'b0)
	) u_chan0 (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.evt      (chan0_evt),
		.flags_we (ch0_flags_we),
		.ena_we   (ch0_ena_we),
		.wdata    (w_data_r),
		.flags_r  (ch0_flags),
		.ena_r    (ch0_ena),
		.spare_r  (),
		.irq      (chan0_irq)
	);

	// Channel 1 keeps spare bits 7:4, shared by both of its registers
	scife_chan #(
		.HAS_SPARE (1'b1)
	) u_chan1 (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.evt      (chan1_evt),
		.flags_we (ch1_flags_we),
		.ena_we   (ch1_ena_we),
		.wdata    (w_data_r),
		.flags_r  (ch1_flags),
		.ena_r    (ch1_ena),
		.spare_r  (ch1_spare),
		.irq      (chan1_irq)
	);

	// Bits owned by other modules read as zero here
	always_comb
	begin
		rd_nxt = 8'h00;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			SCIFE_OFS_CH0_FLAGS: rd_nxt = {6'h00, ch0_flags};
			SCIFE_OFS_CH0_ENA:   rd_nxt = {6'h00, ch0_ena};
			SCIFE_OFS_CH1_ENA:   rd_nxt = {ch1_spare, 2'h0, ch1_ena};
			SCIFE_OFS_CH1_FLAGS: rd_nxt = {ch1_spare, 2'h0, ch1_flags};
			default:             rd_hit = 1'b0;
		endcase
	end

	// One read in flight: the next address waits until the data is taken
	assign s_axi_arready = !s_axi_rvalid;

	// Read data stand from the handshake until rready is seen
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_rvalid <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			s_axi_rvalid <= 1'b1;
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Payload is captured only at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= SCIFE_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rdata <= {24'h00_0000, rd_nxt};
			s_axi_rresp <= rd_hit ? SCIFE_RESP_OKAY : SCIFE_RESP_SLVERR;
		end
	end
endmodule
`default_nettype wire

// file: hdl/scife_pkg.sv
// Package for the serial channel interrupt flag and enable register bank
package scife_pkg;
	localparam logic [3:0] SCIFE_OFS_CH0_FLAGS  = 4'h0;
	localparam logic [3:0] SCIFE_OFS_CH0_ENA    = 4'h4;
	localparam logic [3:0] SCIFE_OFS_CH1_ENA    = 4'h8;
	localparam logic [3:0] SCIFE_OFS_CH1_FLAGS  = 4'hC;
	localparam int         SCIFE_RX_BIT         = 0;
	localparam int         SCIFE_TX_BIT         = 1;
	localparam int         SCIFE_SPARE_LSB      = 4;
	localparam logic [1:0] SCIFE_FLAGS_RST      = 2'h2;
	localparam logic [1:0] SCIFE_ENA_RST        = 2'h0;
	localparam logic [3:0] SCIFE_SPARE_RST      = 4'h0;
	localparam logic [1:0] SCIFE_RESP_OKAY      = 2'h0;
	localparam logic [1:0] SCIFE_RESP_SLVERR    = 2'h2;

	// Per-channel events from the serial engine
	typedef struct packed {
		logic tx_empty;
		logic rx_done;
		logic soft_reset_hold;
	} scife_chan_evt_t;

	// Per-channel interrupt requests
	typedef struct packed {
		logic tx_irq;
		logic rx_irq;
	} scife_chan_irq_t;
endpackage

// file: hdl/scife_chan.sv
// One channel's pending flags, enables and spare bits
`timescale 1ns/10ps
`default_nettype none
module scife_chan
	import scife_pkg::*;
#(
	parameter bit HAS_SPARE = 1'b1
)
(
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// Engine events
	input  wire scife_chan_evt_t evt,
	// Register writes
	input  wire logic            flags_we,
	input  wire logic            ena_we,
	input  wire logic [7:0]      wdata,
	// State
	output logic [1:0]           flags_r,
	output logic [1:0]           ena_r,
	output logic [3:0]           spare_r,
	output scife_chan_irq_t      irq
);
	logic [1:0] flags_nxt;

	// Hardware set wins over a software write in the same cycle
	always_comb
	begin
		flags_nxt = flags_we ? wdata[1:0] : flags_r;
		if (evt.tx_empty)
			flags_nxt[SCIFE_TX_BIT] = 1'b1;
		if (evt.rx_done)
			flags_nxt[SCIFE_RX_BIT] = 1'b1;
		if (evt.soft_reset_hold)
		begin
			flags_nxt[SCIFE_TX_BIT] = 1'b1;
			flags_nxt[SCIFE_RX_BIT] = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_r <= SCIFE_FLAGS_RST;
		else
			flags_r <= flags_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ena_r <= SCIFE_ENA_RST;
		else if (evt.soft_reset_hold)
			ena_r <= SCIFE_ENA_RST;
		else if (ena_we)
			ena_r <= wdata[1:0];
	end

	// Spare bits only exist on the channel whose registers own them; either register writes them
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !HAS_SPARE)
			spare_r <= SCIFE_SPARE_RST;
		else if (ena_we || flags_we)
			spare_r <= wdata[SCIFE_SPARE_LSB +: 4];
	end

	assign irq.tx_irq = flags_r[SCIFE_TX_BIT] & ena_r[SCIFE_TX_BIT];
	assign irq.rx_irq = flags_r[SCIFE_RX_BIT] & ena_r[SCIFE_RX_BIT];
endmodule
`default_nettype wire

// file: verification/scife_monitor.sv
// Port checks for the serial channel interrupt bank
`timescale 1ns/10ps
`default_nettype none
module scife_monitor
	import scife_pkg::*;
(
	// Clock and reset
	input wire logic            aclk,
	input wire logic            aresetn,
	// Bus and channels
	input wire logic            s_axi_awready,
	input wire logic            s_axi_wready,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready,
	input wire logic [31:0]     s_axi_rdata,
	input wire scife_chan_evt_t chan0_evt,
	input wire scife_chan_evt_t chan1_evt,
	input wire scife_chan_irq_t chan0_irq,
	input wire scife_chan_irq_t chan1_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_irq_reset_clear: assert property ($past(!aresetn) |-> !chan0_irq && !chan1_irq)
		else $error("irq after reset");
	a_srst0_quiet: assert property (chan0_evt.soft_reset_hold |=> !chan0_irq)
		else $error("chan0 irq in soft reset");
	a_srst1_quiet: assert property (chan1_evt.soft_reset_hold |=> !chan1_irq)
		else $error("chan1 irq in soft reset");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read late");
	a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read unasked");
	a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper bits set");
	a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read stuck");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready in response");
	a_wdata_block: assert property (s_axi_bvalid |-> !s_axi_wready)
		else $error("wready in response");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response stuck");
	a_write_cause: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write response unasked");
endmodule
bind scife_top scife_monitor scife_monitor_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bready(s_axi_bready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.chan0_evt(chan0_evt), .chan1_evt(chan1_evt), .chan0_irq(chan0_irq), .chan1_irq(chan1_irq));
`default_nettype wire

// file: verification/scife_top_tb.sv
// Self-checking bench for the serial channel interrupt bank
`timescale 1ns/10ps
`default_nettype none
module scife_top_tb import scife_pkg::*;;
	logic            aclk, aresetn, awv, wv, bry, arv, rry, awr, wrr, bv, arr, rv;
	logic [3:0]      awa, ara, ws;
	logic [31:0]     wd, rdd;
	logic [1:0]      br, rr;
	scife_chan_evt_t e0, e1;
	scife_chan_irq_t q0, q1;
	int              failures, num_checks;
	scife_top scife_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdd), .s_axi_rresp(rr),
		.chan0_evt(e0), .chan1_evt(e1), .chan0_irq(q0), .chan1_irq(q1));
	initial
	begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end
	task automatic chk(input string n, input logic [33:0] g, e);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Response ready held from the start, so no stall path here
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = SCIFE_RESP_OKAY);
		@(posedge aclk);
		awv <= 1'h1;
		wv <= 1'h1;
		bry <= 1'h1;
		awa <= a;
		wd <= {24'h0, d};
		do
		begin
			@(posedge aclk);
			if (awr) awv <= 1'h0;
			if (wrr) wv <= 1'h0;
		end
		while (!bv);
		bry <= 1'h0;
		chk("bresp", br, r);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = SCIFE_RESP_OKAY);
		@(posedge aclk);
		arv <= 1'h1;
		rry <= 1'h1;
		ara <= a;
		do
		begin
			@(posedge aclk);
			if (arr) arv <= 1'h0;
		end
		while (!rv);
		rry <= 1'h0;
		chk("read", {rr, rdd}, {r, 24'h0, d});
	endtask
	task complete_run;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge aclk);
		failures++;
		complete_run;
	end
	initial
	begin
		{aresetn, awv, wv, bry, arv, rry, awa, ara, wd, e0, e1} = 0;
		ws = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rd(SCIFE_OFS_CH0_FLAGS, 8'h02);
		rd(SCIFE_OFS_CH0_ENA, 8'h00);
		rd(SCIFE_OFS_CH1_ENA, 8'h00);
		rd(SCIFE_OFS_CH1_FLAGS, 8'h02);
		wr(SCIFE_OFS_CH0_FLAGS, 8'hFC);
		rd(SCIFE_OFS_CH0_FLAGS, 8'h00);
		wr(SCIFE_OFS_CH1_ENA, 8'hFE);
		rd(SCIFE_OFS_CH1_ENA, 8'hF2);
		rd(SCIFE_OFS_CH1_FLAGS, 8'hF2);
		chk("irq1", q1, 2'h2);
		wr(SCIFE_OFS_CH1_ENA, 8'h03);
		wr(SCIFE_OFS_CH1_FLAGS, 8'h00);
		chk("irq1", q1, 2'h0);
		@(posedge aclk);
		e1 <= 3'h2;
		@(posedge aclk);
		e1 <= 3'h4;
		@(posedge aclk);
		e1 <= 3'h0;
		@(posedge aclk);
		chk("irq1", q1, 2'h3);
		rd(SCIFE_OFS_CH1_FLAGS, 8'h03);
		wr(SCIFE_OFS_CH1_FLAGS, 8'h5B);
		rd(SCIFE_OFS_CH1_ENA, 8'h53);
		rd(SCIFE_OFS_CH1_FLAGS, 8'h53);
		e0 <= 3'h4;
		wr(SCIFE_OFS_CH0_FLAGS, 8'h01);
		rd(SCIFE_OFS_CH0_FLAGS, 8'h03);
		wr(SCIFE_OFS_CH0_ENA, 8'hFF);
		rd(SCIFE_OFS_CH0_ENA, 8'h03);
		ws <= 4'hE;
		wr(SCIFE_OFS_CH0_ENA, 8'h00);
		ws <= 4'hF;
		rd(SCIFE_OFS_CH0_ENA, 8'h03);
		chk("irq0", q0, 2'h3);
		e0 <= 3'h1;
		e1 <= 3'h1;
		wr(SCIFE_OFS_CH0_ENA, 8'h03);
		chk("irq0", q0, 2'h0);
		chk("irq1", q1, 2'h0);
		rd(SCIFE_OFS_CH0_ENA, 8'h00);
		rd(SCIFE_OFS_CH0_FLAGS, 8'h02);
		rd(SCIFE_OFS_CH1_ENA, 8'h50);
		rd(SCIFE_OFS_CH1_FLAGS, 8'h52);
		e0 <= 3'h0;
		e1 <= 3'h0;
		wr(4'h2, 8'hFF, SCIFE_RESP_SLVERR);
		rd(4'h2, 8'h00, SCIFE_RESP_SLVERR);
		rd(SCIFE_OFS_CH0_FLAGS, 8'h02);
		wr(SCIFE_OFS_CH0_FLAGS, 8'h01);
		wr(SCIFE_OFS_CH1_ENA, 8'hF3);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(SCIFE_OFS_CH0_FLAGS, 8'h02);
		rd(SCIFE_OFS_CH1_ENA, 8'h00);
		rd(SCIFE_OFS_CH1_FLAGS, 8'h02);
		chk("irq1", q1, 2'h0);
		complete_run;
	end
endmodule
`default_nettype wire
